// *** rtl/hpdp_consts.svh ***
// Constants of the host parallel debug port: offsets, fields, reset values.
// Assumes inclusion by the design file and the bench only.
`ifndef HPDP_CONSTS_SVH
`define HPDP_CONSTS_SVH
`define HPDP_OFF_STATUS 12'h000
`define HPDP_OFF_CTRL 12'h004
`define HPDP_OFF_ADDR 12'h008
`define HPDP_OFF_TXDATA 12'h00c
`define HPDP_OFF_RXDATA 12'h010
`define HPDP_BIT_DTR 15
`define HPDP_BIT_HNMI 14
`define HPDP_BIT_IACK_N 13
`define HPDP_BIT_SEL 12
`define HPDP_BIT_WR_REQ_N 11
`define HPDP_BIT_RD_DONE_N 10
`define HPDP_BIT_ADAPTER 9
`define HPDP_BIT_PWR_N 8
`define HPDP_MODULE_LSB 4
`define HPDP_BIT_BKPT_N 3
`define HPDP_OPTION_LSB 0
`define HPDP_CTRL_ACK 0
`define HPDP_CTRL_REQ 1
`define HPDP_CTRL_DRIVE 2
`define HPDP_CTRL_IDENT 3
`define HPDP_CTRL_HIRQ 4
`define HPDP_CTRL_CLRNMI 5
`define HPDP_CTRL_RST 8'h00
`define HPDP_ADDR_RST 3'h0
`define HPDP_SRC_RST 2'h3
`define HPDP_TD_RST 2'h2
`define HPDP_STRAP_RST 7'h07
`define HPDP_RESET_NS 1000
`define HPDP_CLK_NS 100
`define HPDP_RESET_CYC ((`HPDP_RESET_NS + `HPDP_CLK_NS - 1) / `HPDP_CLK_NS)
`endif

// *** rtl/hpdp_host_port.sv ***
// Host parallel debug port: board side of the host adapter link, APB registers.
// Assumes host pins and board straps asynchronous to ref_clk; all pass two flip-flops.
//
// Function
// - Compare three board-select inputs with the configured slave address.
// - Broadcast select makes reset or abort act regardless of address.
// - Host break with address match or broadcast raises level-7 NMI.
// - Host reset with address match or broadcast resets the board.
// - Interrupt-acknowledge high gives soft reset, low gives hard reset.
// - Host write request is answered by the board acknowledge output.
// - Board starts board-to-host write with its request; host acknowledges.
// - Host interrupt is an open-collector line shared by all boards.
// - Each board drives its own interrupt-identify output for host polling.
// - Interrupt acknowledge from host releases the shared interrupt line.
// - Interrupt acknowledge clears the per-board interrupt-identify output.
// - Bytes move both ways over an eight-line bidirectional data bus.
// - Sixteen-bit read-only status register reports board and port state.
// - Bit 14 low: last NMI from host; bit 3 low: from breakpoint.
// - Bit 13 low while a host interrupt acknowledge is in progress.
// - Bit 12 high while the host addresses this board.
// - Bit 11 low on host write request; bit 10 low on host read done.
// - Bit 9 high with adapter connected; bit 8 low with host powered.
// - Bits 7 to 4 return the memory module presence-detect code.
// - Bit 15 low when a terminal is on the serial port.
// - Bits 2 to 0 high when option switches 5, 4, 3 are on.
// - Data lines reach the processor through the RXDATA and TXDATA registers; ctrl bit 2 drives them out.
`timescale 1ns/10ps
`include "hpdp_consts.svh"
module hpdp_host_port (
	// Clock, enable and reset
	input wire logic ref_clk,
	input wire logic clkEn,
	input wire logic reset,
	// APB slave
	input wire hpdp_pkg::hpdp_apb_req_s apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Host adapter pins
	input wire hpdp_pkg::hpdp_host_s hostPins,
	input wire logic [7:0] parallelDataIn,
	output logic [7:0] parallelDataOut,
	output logic parallelDataOeN,
	output logic boardWriteAck,
	output logic boardWriteRequest,
	output logic boardIrqIdentify,
	output logic sharedHostIrqOut,
	output logic sharedHostIrqOeN,
	// Board straps and local sources
	input wire logic [3:0] moduleCode,
	input wire logic [2:0] optionSwitchOnN,
	input wire logic terminalReadyN,
	input wire logic breakpointNmi,
	// Effects on the processor and board
	output logic nmiLevel7,
	output logic hardResetReq,
	output logic softResetReq
);
	import hpdp_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	hpdp_host_s hostMeta_q, hostMeta_d, hostSync_q, hostSync_d;
	logic [7:0] dataMeta_q, dataMeta_d, dataSync_q, dataSync_d;
	logic [1:0] tdMeta_q, tdMeta_d, tdSync_q, tdSync_d;
	logic [6:0] strapMeta_q, strapMeta_d, strapSync_q, strapSync_d;

	always_comb begin
		hostMeta_d = hostMeta_q;
		hostSync_d = hostSync_q;
		dataMeta_d = dataMeta_q;
		dataSync_d = dataSync_q;
		tdMeta_d = tdMeta_q;
		tdSync_d = tdSync_q;
		strapMeta_d = strapMeta_q;
		strapSync_d = strapSync_q;
		if (clkEn) begin
			hostMeta_d = hostPins;
			hostSync_d = hostMeta_q;
			dataMeta_d = parallelDataIn;
			dataSync_d = dataMeta_q;
			tdMeta_d = {terminalReadyN, breakpointNmi};
			tdSync_d = tdMeta_q;
			strapMeta_d = {moduleCode, optionSwitchOnN};
			strapSync_d = strapMeta_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			hostMeta_q <= '0;
			hostSync_q <= '0;
			dataMeta_q <= 8'h00;
			dataSync_q <= 8'h00;
			tdMeta_q <= `HPDP_TD_RST;
			tdSync_q <= `HPDP_TD_RST;
			strapMeta_q <= `HPDP_STRAP_RST;
			strapSync_q <= `HPDP_STRAP_RST;
		end else begin
			hostMeta_q <= hostMeta_d;
			hostSync_q <= hostSync_d;
			dataMeta_q <= dataMeta_d;
			dataSync_q <= dataSync_d;
			tdMeta_q <= tdMeta_d;
			tdSync_q <= tdSync_d;
			strapMeta_q <= strapMeta_d;
			strapSync_q <= strapSync_d;
		end
	end

	// ----------------------------------------------------------------
	// Selection and host events
	// ----------------------------------------------------------------
	logic [2:0] slaveAddr_q;
	logic boardAddressed;
	logic hostAttached;
	logic breakHit;
	logic resetHit;
	logic iackPrev_q, iackPrev_d;
	logic iackRise;

	assign boardAddressed = (hostSync_q.boardSelectAddr == slaveAddr_q);
	assign hostAttached = ~hostSync_q.hostEnableN;
	assign breakHit = hostAttached && hostSync_q.hostBreakIn
		&& (boardAddressed || hostSync_q.broadcastSelect);
	assign resetHit = hostAttached && hostSync_q.hostResetIn
		&& (boardAddressed || hostSync_q.broadcastSelect);
	assign iackRise = hostSync_q.intAck && !iackPrev_q;

	// ----------------------------------------------------------------
	// Reset generator
	// ----------------------------------------------------------------
	hpdp_rst_e rstState_q, rstState_d;
	logic [7:0] rstCnt_q, rstCnt_d;

	always_comb begin
		rstState_d = rstState_q;
		rstCnt_d = rstCnt_q;
		if (clkEn) begin
			case (rstState_q)
				HPDP_RST_IDLE: begin
					if (resetHit) begin
						rstCnt_d = 8'(`HPDP_RESET_CYC);
						rstState_d = hostSync_q.intAck ? HPDP_RST_SOFT : HPDP_RST_HARD;
					end
				end
				HPDP_RST_HARD, HPDP_RST_SOFT: begin
					if (rstCnt_q > 8'h01) begin
						rstCnt_d = rstCnt_q - 8'h01;
					end else if (!resetHit) begin
						rstCnt_d = 8'h00;
						rstState_d = HPDP_RST_IDLE;
					end
				end
				default: begin
					rstState_d = HPDP_RST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rstState_q <= HPDP_RST_IDLE;
			rstCnt_q <= 8'h00;
		end else begin
			rstState_q <= rstState_d;
			rstCnt_q <= rstCnt_d;
		end
	end

	assign hardResetReq = (rstState_q == HPDP_RST_HARD);
	assign softResetReq = (rstState_q == HPDP_RST_SOFT);

	// ----------------------------------------------------------------
	// NMI source and host interrupt
	// ----------------------------------------------------------------
	logic [1:0] nmiSrcN_q, nmiSrcN_d;
	logic nmi_q, nmi_d;
	logic hostIrq_q, hostIrq_d;
	logic ident_q, ident_d;
	logic [7:0] ctrl_q, ctrl_d;
	logic bkPrev_q, bkPrev_d;
	logic breakPrev_q, breakPrev_d;
	logic bkRise, breakRise;
	logic ctrlWrite;
	logic [31:0] wdata;

	assign bkRise = tdSync_q[0] && !bkPrev_q;
	assign breakRise = breakHit && !breakPrev_q;

	always_comb begin
		nmiSrcN_d = nmiSrcN_q;
		nmi_d = nmi_q;
		hostIrq_d = hostIrq_q;
		ident_d = ident_q;
		iackPrev_d = iackPrev_q;
		bkPrev_d = bkPrev_q;
		breakPrev_d = breakPrev_q;
		if (clkEn) begin
			iackPrev_d = hostSync_q.intAck;
			bkPrev_d = tdSync_q[0];
			breakPrev_d = breakHit;
			if (ctrlWrite && wdata[`HPDP_CTRL_CLRNMI]) begin
				nmi_d = 1'b0;
			end
			if (ctrlWrite && wdata[`HPDP_CTRL_HIRQ]) begin
				hostIrq_d = 1'b1;
			end
			if (ctrlWrite) begin
				ident_d = wdata[`HPDP_CTRL_IDENT];
			end
			if (iackRise) begin
				hostIrq_d = 1'b0;
				ident_d = 1'b0;
			end
			if (breakRise) begin
				nmi_d = 1'b1;
				nmiSrcN_d = 2'b01;
			end else if (bkRise) begin
				nmi_d = 1'b1;
				nmiSrcN_d = 2'b10;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nmiSrcN_q <= `HPDP_SRC_RST;
			nmi_q <= 1'b0;
			hostIrq_q <= 1'b0;
			ident_q <= 1'b0;
			iackPrev_q <= 1'b0;
			bkPrev_q <= 1'b0;
			breakPrev_q <= 1'b0;
		end else begin
			nmiSrcN_q <= nmiSrcN_d;
			nmi_q <= nmi_d;
			hostIrq_q <= hostIrq_d;
			ident_q <= ident_d;
			iackPrev_q <= iackPrev_d;
			bkPrev_q <= bkPrev_d;
			breakPrev_q <= breakPrev_d;
		end
	end

	assign nmiLevel7 = nmi_q;
	assign sharedHostIrqOut = 1'b0;
	assign sharedHostIrqOeN = ~hostIrq_q;
	assign boardIrqIdentify = ident_q;

	// ----------------------------------------------------------------
	// APB registers and data bus
	// ----------------------------------------------------------------
	logic [7:0] txData_q, txData_d;
	logic [2:0] slaveAddr_d;
	logic [15:0] status;
	logic apbAccess;
	logic [11:0] offs;

	assign apbAccess = apbReq.psel && apbReq.penable && clkEn;
	assign offs = apbReq.paddr[11:0];
	assign wdata = apbReq.pwdata;
	assign ctrlWrite = apbAccess && apbReq.pwrite && (offs == `HPDP_OFF_CTRL);

	always_comb begin
		status = 16'h0000;
		status[`HPDP_BIT_DTR] = tdSync_q[1];
		status[`HPDP_BIT_HNMI] = nmiSrcN_q[1];
		status[`HPDP_BIT_IACK_N] = ~hostSync_q.intAck;
		status[`HPDP_BIT_SEL] = boardAddressed;
		status[`HPDP_BIT_WR_REQ_N] = ~hostSync_q.hostWrReq;
		status[`HPDP_BIT_RD_DONE_N] = ~hostSync_q.hostReadAck;
		status[`HPDP_BIT_ADAPTER] = hostAttached;
		status[`HPDP_BIT_PWR_N] = hostSync_q.hostPoweredN;
		status[`HPDP_MODULE_LSB +: 4] = strapSync_q[6:3];
		status[`HPDP_BIT_BKPT_N] = nmiSrcN_q[0];
		status[`HPDP_OPTION_LSB +: 3] = ~strapSync_q[2:0];
	end

	always_comb begin
		ctrl_d = ctrl_q;
		slaveAddr_d = slaveAddr_q;
		txData_d = txData_q;
		if (apbAccess && apbReq.pwrite) begin
			case (offs)
				`HPDP_OFF_CTRL: ctrl_d = wdata[7:0];
				`HPDP_OFF_ADDR: slaveAddr_d = wdata[2:0];
				`HPDP_OFF_TXDATA: txData_d = wdata[7:0];
				default: ctrl_d = ctrl_q;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ctrl_q <= `HPDP_CTRL_RST;
			slaveAddr_q <= `HPDP_ADDR_RST;
			txData_q <= 8'h00;
		end else begin
			ctrl_q <= ctrl_d;
			slaveAddr_q <= slaveAddr_d;
			txData_q <= txData_d;
		end
	end

	always_comb begin
		prdata = 32'h00000000;
		pslverr = 1'b0;
		case (offs)
			`HPDP_OFF_STATUS: prdata = {16'h0000, status};
			`HPDP_OFF_CTRL: prdata = {24'h000000, ctrl_q};
			`HPDP_OFF_ADDR: prdata = {29'h00000000, slaveAddr_q};
			`HPDP_OFF_TXDATA: prdata = {24'h000000, txData_q};
			`HPDP_OFF_RXDATA: prdata = {24'h000000, dataSync_q};
			default: pslverr = apbReq.psel && apbReq.penable;
		endcase
		if (apbReq.pwrite && offs == `HPDP_OFF_STATUS) begin
			pslverr = apbReq.psel && apbReq.penable;
		end
	end

	assign pready = clkEn;
	assign boardWriteAck = ctrl_q[`HPDP_CTRL_ACK];
	assign boardWriteRequest = ctrl_q[`HPDP_CTRL_REQ];
	assign parallelDataOut = txData_q;
	assign parallelDataOeN = ~ctrl_q[`HPDP_CTRL_DRIVE];

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_iack_clears_ident: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && iackRise |=> !boardIrqIdentify)
		else $error("identify not cleared by acknowledge");
	a_iack_release_irq: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && iackRise |=> sharedHostIrqOeN)
		else $error("shared irq not released");
	a_break_raises_nmi: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && breakRise |=> nmiLevel7 && !status[`HPDP_BIT_HNMI])
		else $error("host break gave no nmi");
	a_reset_type_soft: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && rstState_q == HPDP_RST_IDLE && resetHit && hostSync_q.intAck
		|=> softResetReq && !hardResetReq)
		else $error("soft reset not chosen");
	a_reset_type_hard: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && rstState_q == HPDP_RST_IDLE && resetHit && !hostSync_q.intAck
		|=> hardResetReq)
		else $error("hard reset not chosen");
	a_sync_select_flag: assert property (@(posedge ref_clk) disable iff (reset)
		$past(clkEn) && $past(clkEn, 2) && !$past(reset) && !$past(reset, 2)
		|-> status[`HPDP_BIT_SEL]
		== ($past(hostPins.boardSelectAddr, 2) == slaveAddr_q))
		else $error("select flag wrong");
	a_status_reqflag: assert property (@(posedge ref_clk) disable iff (reset)
		$past(clkEn) && $past(clkEn, 2) && !$past(reset) && !$past(reset, 2)
		|-> status[`HPDP_BIT_WR_REQ_N] == !$past(hostPins.hostWrReq, 2))
		else $error("write request flag stale");
	a_bkpt_source_flag: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && bkRise && !breakRise |=> nmiLevel7 && !status[`HPDP_BIT_BKPT_N])
		else $error("breakpoint nmi source not flagged");
	a_broadcast_reset: assert property (@(posedge ref_clk) disable iff (reset)
		clkEn && hostAttached && hostSync_q.hostResetIn && hostSync_q.broadcastSelect
		&& rstState_q == HPDP_RST_IDLE |=> hardResetReq || softResetReq)
		else $error("broadcast reset ignored");
	a_status_readonly: assert property (@(posedge ref_clk) disable iff (reset)
		apbReq.psel && apbReq.penable && apbReq.pwrite && offs == `HPDP_OFF_STATUS
		|-> pslverr)
		else $error("status write not refused");
endmodule

// *** rtl/hpdp_pkg.sv ***
// Types of the host parallel debug port.
// Assumes nothing beyond the constants header.
package hpdp_pkg;
	typedef enum logic [1:0] {
		HPDP_RST_IDLE = 2'b00,
		HPDP_RST_HARD = 2'b01,
		HPDP_RST_SOFT = 2'b10
	} hpdp_rst_e;
	typedef struct packed {
		logic [2:0] boardSelectAddr;
		logic broadcastSelect;
		logic hostBreakIn;
		logic hostResetIn;
		logic hostWrReq;
		logic hostReadAck;
		logic intAck;
		logic hostEnableN;
		logic hostPoweredN;
	} hpdp_host_s;
	typedef struct packed {
		logic [31:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} hpdp_apb_req_s;
endpackage

// *** sim/hpdp_host_model.sv ***
// Host adapter model: drives host pins and the data bus, answers board writes.
// Assumes the bench calls its tasks right after a rising edge of ref_clk.
`timescale 1ns/10ps
module hpdp_host_model (
	// Clock
	input wire logic ref_clk,
	// Toward the board
	output hpdp_pkg::hpdp_host_s hostPins,
	output logic [7:0] parallelDataIn,
	// From the board
	input wire logic [7:0] parallelDataOut,
	input wire logic parallelDataOeN,
	input wire logic boardWriteRequest,
	input wire logic boardWriteAck,
	input wire logic sharedHostIrqOut,
	input wire logic sharedHostIrqOeN,
	// Seen by the bench
	output logic hostIrqLine,
	output logic [7:0] gotByte
);
	import hpdp_pkg::*;
	logic hostDrive = 1'b0;
	logic [7:0] hostByte = 8'h00;
	logic [7:0] lastWire = 8'h00;
	int ackDelay = 1;
	initial begin
		hostPins = '0;
		hostPins.boardSelectAddr = 3'h5;
		hostPins.hostEnableN = 1'b0;
		gotByte = 8'h00;
	end
	// Undriven bus shows a changing pattern, never the last value
	always_comb parallelDataIn = !parallelDataOeN ? parallelDataOut :
		(hostDrive ? hostByte : ~lastWire);
	always @(posedge ref_clk) lastWire <= parallelDataIn;
	// Pull-up on the shared line
	assign hostIrqLine = sharedHostIrqOeN ? 1'b1 : sharedHostIrqOut;
	always @(posedge ref_clk) begin
		if (boardWriteRequest && !hostPins.hostReadAck) begin
			repeat (ackDelay) @(posedge ref_clk);
			gotByte <= parallelDataIn;
			hostPins.hostReadAck <= 1'b1;
		end else if (!boardWriteRequest) begin
			hostPins.hostReadAck <= 1'b0;
		end
	end
	task automatic setPins(input logic [2:0] sel, input logic all, brk, rst, iack, pwrN);
		hostPins.boardSelectAddr <= sel;
		hostPins.broadcastSelect <= all;
		hostPins.hostBreakIn <= brk;
		hostPins.hostResetIn <= rst;
		hostPins.intAck <= iack;
		hostPins.hostPoweredN <= pwrN;
	endtask
	task automatic hostWrite(input logic [7:0] b);
		hostByte <= b;
		hostDrive <= 1'b1;
		hostPins.hostWrReq <= 1'b1;
		while (!boardWriteAck) @(posedge ref_clk);
		@(posedge ref_clk);
		hostPins.hostWrReq <= 1'b0;
		hostDrive <= 1'b0;
	endtask
endmodule

// *** sim/tb.sv ***
// Bench for the host parallel debug port: APB tasks plus host model tasks.
// Assumes the host model file compiles first.
`timescale 1ns/10ps
`include "hpdp_consts.svh"
`define CHK(g, x) begin totalChecks++; if ((g) !== (x)) begin badCount++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, g, x); end end
module tb;
	import hpdp_pkg::*;
	localparam logic [31:0] aStat = 32'(`HPDP_OFF_STATUS);
	localparam logic [31:0] aCtrl = 32'(`HPDP_OFF_CTRL);
	localparam logic [31:0] aAddr = 32'(`HPDP_OFF_ADDR);
	localparam logic [31:0] aTx = 32'(`HPDP_OFF_TXDATA);
	localparam logic [31:0] aRx = 32'(`HPDP_OFF_RXDATA);
	logic ref_clk = 0, clkEn = 1, reset = 1, terminalReadyN = 1, breakpointNmi = 0;
	logic [3:0] moduleCode = 4'ha;
	logic [2:0] optionSwitchOnN = 3'b010;
	hpdp_apb_req_s apbReq = '0;
	hpdp_host_s hostPins;
	logic [7:0] pdIn, pdOut, gotByte;
	logic [31:0] prdata, rd;
	logic pready, pslverr, err, pdOeN, wAck, wReq, ident, irqOut, irqOeN, irqLine;
	logic nmi, hardRst, softRst;
	int badCount = 0, totalChecks = 0, cyc = 0;
	hpdp_host_port dut_u (.ref_clk(ref_clk), .clkEn(clkEn), .reset(reset), .apbReq(apbReq),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hostPins(hostPins),
		.parallelDataIn(pdIn), .parallelDataOut(pdOut), .parallelDataOeN(pdOeN),
		.boardWriteAck(wAck), .boardWriteRequest(wReq), .boardIrqIdentify(ident),
		.sharedHostIrqOut(irqOut), .sharedHostIrqOeN(irqOeN), .moduleCode(moduleCode),
		.optionSwitchOnN(optionSwitchOnN), .terminalReadyN(terminalReadyN),
		.breakpointNmi(breakpointNmi), .nmiLevel7(nmi), .hardResetReq(hardRst),
		.softResetReq(softRst));
	hpdp_host_model host_u (.ref_clk(ref_clk), .hostPins(hostPins), .parallelDataIn(pdIn),
		.parallelDataOut(pdOut), .parallelDataOeN(pdOeN), .boardWriteRequest(wReq),
		.boardWriteAck(wAck), .sharedHostIrqOut(irqOut), .sharedHostIrqOeN(irqOeN),
		.hostIrqLine(irqLine), .gotByte(gotByte));
	initial forever #50 ref_clk = ~ref_clk;
	// ----------------------------------------
	// Bus tasks and closing
	// ----------------------------------------
	task automatic apb(input logic w, input logic [31:0] a, d);
		@(posedge ref_clk);
		apbReq.paddr <= a;
		apbReq.pwrite <= w;
		apbReq.pwdata <= d;
		apbReq.psel <= 1'b1;
		@(posedge ref_clk);
		apbReq.penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
	endtask
	task automatic rdChk(input logic [31:0] a, m, x);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, x)
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			badCount++;
			conclude();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		waitc(12);
		reset <= 1'b0;
		rdChk(aStat, 32'hffffffff, 32'h0000eead);
		rdChk(aCtrl, 32'hffffffff, 32'h0);
		rdChk(aAddr, 32'hffffffff, 32'h0);
		apb(1'b1, aStat, 32'h0);
		`CHK(err, 1'b1)
		rdChk(32'h14, 32'hffffffff, 32'h0);
		`CHK(err, 1'b1)
		moduleCode <= 4'h5;
		optionSwitchOnN <= 3'b111;
		terminalReadyN <= 1'b0;
		host_u.setPins(3'h5, 0, 0, 0, 0, 1);
		waitc(4);
		rdChk(aStat, 32'h81f7, 32'h0150);
		$display("test status done");
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, aAddr, 32'(i));
			waitc(2);
			rdChk(aStat, 32'h1000, (i == 5) ? 32'h1000 : 32'h0);
		end
		apb(1'b1, aAddr, 32'h3);
		host_u.setPins(3'h3, 0, 1, 0, 0, 1);
		waitc(4);
		`CHK(nmi, 1'b1)
		rdChk(aStat, 32'h4008, 32'h0008);
		host_u.setPins(3'h5, 0, 0, 0, 0, 1);
		apb(1'b1, aCtrl, 32'h20);
		waitc(2);
		`CHK(nmi, 1'b0)
		host_u.setPins(3'h5, 0, 1, 0, 0, 1);
		waitc(4);
		`CHK(nmi, 1'b0)
		host_u.setPins(3'h5, 1, 0, 0, 0, 1);
		waitc(4);
		host_u.setPins(3'h5, 1, 1, 0, 0, 1);
		waitc(4);
		`CHK(nmi, 1'b1)
		host_u.setPins(3'h5, 0, 0, 0, 0, 1);
		apb(1'b1, aCtrl, 32'h20);
		breakpointNmi <= 1'b1;
		waitc(4);
		`CHK(nmi, 1'b1)
		rdChk(aStat, 32'h4008, 32'h4000);
		breakpointNmi <= 1'b0;
		apb(1'b1, aCtrl, 32'h20);
		apb(1'b1, aAddr, 32'h5);
		$display("test nmi done");
		for (int m = 0; m < 2; m++) begin
			host_u.setPins(3'h5, 0, 0, 1, m[0], 1);
			waitc(4);
			`CHK({hardRst, softRst}, m ? 2'b01 : 2'b10)
			host_u.setPins(3'h5, 0, 0, 0, 0, 1);
			waitc(16);
			`CHK({hardRst, softRst}, 2'b00)
		end
		$display("test reset done");
		apb(1'b1, aCtrl, 32'h18);
		waitc(1);
		`CHK({irqLine, ident}, 2'b01)
		host_u.setPins(3'h5, 0, 0, 0, 1, 1);
		waitc(3);
		rdChk(aStat, 32'h2000, 32'h0);
		`CHK({irqLine, ident}, 2'b10)
		host_u.setPins(3'h5, 0, 0, 0, 0, 1);
		apb(1'b1, aCtrl, 32'h0);
		$display("test irq done");
		fork
			host_u.hostWrite(8'h3c);
			begin
				waitc(4);
				rdChk(aStat, 32'h800, 32'h0);
				rdChk(aRx, 32'hff, 32'h3c);
				apb(1'b1, aCtrl, 32'h1);
				waitc(1);
				`CHK(wAck, 1'b1)
			end
		join
		apb(1'b1, aCtrl, 32'h0);
		waitc(4);
		rdChk(aStat, 32'h800, 32'h800);
		host_u.ackDelay = 5;
		apb(1'b1, aTx, 32'hc3);
		apb(1'b1, aCtrl, 32'h6);
		waitc(12);
		`CHK(gotByte, 8'hc3)
		rdChk(aStat, 32'h400, 32'h0);
		apb(1'b1, aCtrl, 32'h0);
		waitc(4);
		rdChk(aStat, 32'h400, 32'h400);
		$display("test data done");
		clkEn <= 1'b0;
		breakpointNmi <= 1'b1;
		waitc(6);
		`CHK(nmi, 1'b0)
		clkEn <= 1'b1;
		waitc(4);
		`CHK(nmi, 1'b1)
		breakpointNmi <= 1'b0;
		$display("test enable done");
		conclude();
	end
endmodule
